// file: verilog/acc_conversion_control.sv
// conversion control for a 10-bit successive-approximation converter, AXI4-Lite slave
// assumes one 40 MHz clock, synchronous active-high reset, analog result from outside
//
// Contract
// [R1] any control write aborts and restarts conversion unless channel is all ones
// [R2] done flag is read-only and set at each conversion end
// [R3] done flag clears on control write or low result read
// [R4] interrupt at conversion end when enabled, drops on low result read or control write; a high result read leaves it set
// [R5] continuous mode repeats conversions and updates results each time
// [R6] continuous ends on reset, stop without async clock, clock write, control write
// [R7] after stop abort, only a new control write resumes conversions
// [R8] write with continuous set and valid channel restarts in continuous mode
// [R9] continuous clear: each valid control write gives exactly one conversion
// [R10] 5-bit channel select chooses inputs 0-5, bandgap, high and low reference
// [R11] all-ones channel powers converter off and isolates the pad
// [R12] all-ones write ends continuous with no further conversion
// [R13] converter powers down by itself after a conversion completes; in continuous mode it stays powered
// [R14] break-clear enable set: flags clearable in break, stay cleared after
// [R15] break-clear enable clear: accesses during break leave flags alone
// [R16] two-step clear started before break completes after break
// [R17] no hardware trigger input; software writes start conversions only
// [R18] continuous timing exact only with bus clock at least converter clock
// [R19] 10-bit: after high read, results held until low read; later results lost
// [R20] reserved channel codes accepted, result undefined
// [R21] interrupt stays high while enable and done flag both set
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`default_nettype none
`include "acc_defines.svh"
module acc_conversion_control (
   input wire logic i_clk_sys,
   input wire logic i_reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [9:0] i_sar_result,
   output logic [4:0] o_channel_select,
   output logic o_converter_power,
   output logic o_sample_active,
   output logic o_conversion_irq
);
   // ==========================================================
   // bus slave
   logic aw_q, w_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q, rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] bresp_q, rresp_q;
   logic wr_go, rd_go;

   function automatic logic map_ok(input logic [7:0] a);
      map_ok = (a == `ACC_OFF_SCR) || (a == `ACC_OFF_RESH) || (a == `ACC_OFF_RESL)
         || (a == `ACC_OFF_CLK) || (a == `ACC_OFF_SYS);
   endfunction : map_ok

   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready = !w_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign wr_go = aw_q && w_q && !bvalid_q;
   assign rd_go = s_axi_arvalid && s_axi_arready;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         bvalid_q <= 1'b0;
         bresp_q <= 2'b00;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         bresp_q <= map_ok(awaddr_q) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // register decode
   logic wr_lane0;
   logic wr_scr, wr_clk, wr_sys, rd_resh, rd_resl;
   assign wr_lane0 = wr_go && wstrb_q[0];
   assign wr_scr = wr_lane0 && (awaddr_q == `ACC_OFF_SCR);
   assign wr_clk = wr_lane0 && (awaddr_q == `ACC_OFF_CLK);
   assign wr_sys = wr_lane0 && (awaddr_q == `ACC_OFF_SYS);
   assign rd_resh = rd_go && (s_axi_araddr == `ACC_OFF_RESH);
   assign rd_resl = rd_go && (s_axi_araddr == `ACC_OFF_RESL);

   logic ien_q, cont_q;
   logic [4:0] chan_q;
   logic [7:0] clk_q;
   logic break_clear_enable_q, brk_q, stop_q, aclk_q;
   logic done_q;
   logic [9:0] result_q;
   logic lock_q;
   logic clr_ok;

   // bus accesses only change flags under break when break-clear is enabled
   assign clr_ok = !brk_q || break_clear_enable_q; // [R14] [R15] [R16]

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         ien_q <= 1'b0;
         cont_q <= 1'b0;
         chan_q <= `ACC_CH_OFF;
      end else if (wr_scr) begin
         ien_q <= wdata_q[`ACC_BIT_IEN];
         cont_q <= wdata_q[`ACC_BIT_CONT];
         chan_q <= wdata_q[4:0]; // [R10] [R20]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         clk_q <= `ACC_CLK_RESET;
      end else if (wr_clk) begin
         clk_q <= wdata_q[7:0];
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         break_clear_enable_q <= 1'b0; // [R15]
         brk_q <= 1'b0;
         stop_q <= 1'b0;
         aclk_q <= 1'b0;
      end else if (wr_sys) begin
         break_clear_enable_q <= wdata_q[`ACC_BIT_BREAK_CLEAR_ENABLE];
         brk_q <= wdata_q[`ACC_BIT_BRK];
         stop_q <= wdata_q[`ACC_BIT_STOP];
         aclk_q <= wdata_q[`ACC_BIT_ACLK];
      end
   end

   // ==========================================================
   // conversion sequencer
   acc_pkg::acc_state_e st_q;
   logic [4:0] cnt_q;
   logic start_ok, finish, stop_abort;
   logic [4:0] samp_cyc;

   // no trigger pin exists: only control writes start work
   assign start_ok = wr_scr && (wdata_q[4:0] != `ACC_CH_OFF); // [R1] [R12] [R17]
   assign stop_abort = stop_q && !aclk_q; // [R6] [R7]
   assign samp_cyc = clk_q[`ACC_BIT_LSMP] ? `ACC_LONG_CYC : `ACC_SHORT_CYC; // [R18]
   assign finish = (st_q == acc_pkg::ACC_CONVERT) && (cnt_q == 5'h00);

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         st_q <= acc_pkg::ACC_IDLE;
         cnt_q <= 5'h00;
      end else if (start_ok && !stop_abort) begin
         st_q <= acc_pkg::ACC_SAMPLE; // [R1] [R8] [R9]
         cnt_q <= samp_cyc;
      end else if (wr_scr || wr_clk || stop_abort) begin
         st_q <= acc_pkg::ACC_IDLE; // [R6] [R11] [R12]
         cnt_q <= 5'h00;
      end else begin
         case (st_q)
            acc_pkg::ACC_IDLE: begin
               cnt_q <= 5'h00;
            end
            acc_pkg::ACC_SAMPLE: begin
               if (cnt_q == 5'h00) begin
                  st_q <= acc_pkg::ACC_CONVERT;
                  cnt_q <= `ACC_SAR_CYC;
               end else begin
                  cnt_q <= cnt_q - 5'h01;
               end
            end
            acc_pkg::ACC_CONVERT: begin
               if (cnt_q != 5'h00) begin
                  cnt_q <= cnt_q - 5'h01;
               end else if (cont_q) begin
                  st_q <= acc_pkg::ACC_SAMPLE; // [R5]
                  cnt_q <= samp_cyc;
               end else begin
                  st_q <= acc_pkg::ACC_IDLE; // [R9] [R13]
               end
            end
            default: begin
               st_q <= acc_pkg::ACC_IDLE;
               cnt_q <= 5'h00;
            end
         endcase
      end
   end

   // ==========================================================
   // result registers and interlock
   logic ten_bit;
   assign ten_bit = clk_q[`ACC_BIT_MODE0];

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         result_q <= 10'h000;
      end else if (finish && !lock_q) begin
         result_q <= i_sar_result; // [R5] [R19]
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         lock_q <= 1'b0;
      end else if (rd_resl && clr_ok) begin
         lock_q <= 1'b0;
      end else if (rd_resh && ten_bit && clr_ok) begin
         lock_q <= 1'b1; // [R19] [R16]
      end
   end

   // set wins over clear
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         done_q <= 1'b0;
      end else if (finish) begin
         done_q <= 1'b1; // [R2]
      end else if ((wr_scr || rd_resl) && clr_ok) begin
         done_q <= 1'b0; // [R3] [R4]
      end
   end

   // ==========================================================
   // read data
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= 2'b00;
      end else if (rd_go) begin
         rvalid_q <= 1'b1;
         rresp_q <= map_ok(s_axi_araddr) ? 2'b00 : 2'b10;
         case (s_axi_araddr)
            `ACC_OFF_SCR: rdata_q <= {24'h00_0000, done_q, ien_q, cont_q, chan_q}; // [R2]
            `ACC_OFF_RESH: rdata_q <= ten_bit ? {30'h0000_0000, result_q[9:8]}
                                              : 32'h0000_0000;
            `ACC_OFF_RESL: rdata_q <= ten_bit ? {24'h00_0000, result_q[7:0]}
                                              : {24'h00_0000, result_q[9:2]};
            `ACC_OFF_CLK: rdata_q <= {24'h00_0000, clk_q};
            `ACC_OFF_SYS: rdata_q <= {28'h000_0000, aclk_q, stop_q, brk_q, break_clear_enable_q};
            default: rdata_q <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // converter outputs
   assign o_channel_select = chan_q; // [R10]
   assign o_converter_power = (st_q != acc_pkg::ACC_IDLE); // [R11] [R13]
   assign o_sample_active = (st_q == acc_pkg::ACC_SAMPLE);
   assign o_conversion_irq = done_q && ien_q; // [R4] [R21]

   // ==========================================================
   // checks
   a_write_clears_done: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R3]
      wr_scr && clr_ok && !finish |=> !done_q)
      else $error("done flag not cleared by control write");
   a_finish_sets_done: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R2]
      finish |=> done_q)
      else $error("done flag not set at end of conversion");
   a_irq_follows: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R21]
      finish && ien_q && !wr_scr |=> o_conversion_irq)
      else $error("interrupt missing after conversion");
   a_start_samples: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R1]
      start_ok && !stop_abort |=> o_sample_active && o_converter_power)
      else $error("valid write did not start sampling");
   a_off_stays_idle: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R12]
      wr_scr && !start_ok |=> !o_converter_power)
      else $error("all-ones write left converter running");
   a_single_powers_down: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R13]
      finish && !cont_q && !wr_scr |=> !o_converter_power)
      else $error("single conversion did not power down");
   a_cont_repeats: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R5]
      finish && cont_q && !wr_scr && !wr_clk && !stop_abort |=> o_sample_active)
      else $error("continuous mode did not repeat");
   a_stop_aborts: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R6]
      stop_abort |=> !o_converter_power)
      else $error("stop without async clock did not abort");
   a_break_protects: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R15]
      brk_q && !break_clear_enable_q && done_q |=> done_q)
      else $error("done flag changed during protected break");
   a_lock_holds: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R19]
      lock_q && !rd_resl |=> $stable(result_q))
      else $error("result changed while interlocked");

   // ==========================================================
   // named steps of a conversion
   sequence s_quiet_five;
      (!wr_scr && !wr_clk && !stop_abort) [*5];
   endsequence
   sequence s_quiet_ten;
      s_quiet_five ##1 s_quiet_five;
   endsequence
   sequence s_quiet_long;
      s_quiet_ten ##1 s_quiet_ten ##1 s_quiet_five;
   endsequence
   sequence s_short_start;
      start_ok && !stop_abort && !clk_q[`ACC_BIT_LSMP];
   endsequence
   sequence s_long_start;
      start_ok && !stop_abort && clk_q[`ACC_BIT_LSMP];
   endsequence
   sequence s_to_convert;
      o_sample_active ##1 (o_converter_power && !o_sample_active);
   endsequence

   a_short_sample: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R18]
      s_short_start ##1 s_quiet_five |=> o_converter_power && !o_sample_active)
      else $error("short sample phase has wrong length");
   a_long_sample: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R18]
      s_long_start ##1 s_quiet_long |=> o_converter_power && !o_sample_active)
      else $error("long sample phase has wrong length");
   a_convert_length: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R2]
      s_to_convert ##0 s_quiet_ten |=> finish)
      else $error("conversion phase has wrong length");
   a_write_keeps_clear: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R2]
      wr_scr && !finish && !done_q |=> !done_q)
      else $error("control write set the done flag");
   a_irq_drops: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R4]
      (wr_scr || rd_resl) && clr_ok && !finish |=> !o_conversion_irq)
      else $error("interrupt not dropped by write or low read");
   a_lock_sets: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R19]
      rd_resh && ten_bit && clr_ok |=> lock_q)
      else $error("high read did not lock results");
   a_idle_needs_write: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R7]
      !o_converter_power && !start_ok |=> !o_converter_power)
      else $error("converter woke without a control write");
   a_channel_follows: assert property (@(posedge i_clk_sys) disable iff (i_reset) // [R10]
      wr_scr |=> o_channel_select == $past(wdata_q[4:0]))
      else $error("channel select not taken from control write");
endmodule : acc_conversion_control
`default_nettype wire

// file: verilog/acc_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from design files
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFF_SCR 8'h00
`define ACC_OFF_RESH 8'h04
`define ACC_OFF_RESL 8'h08
`define ACC_OFF_CLK 8'h0C
`define ACC_OFF_SYS 8'h10
`define ACC_SCR_RESET 8'h1F
`define ACC_CLK_RESET 8'h00
`define ACC_BIT_DONE 7
`define ACC_BIT_IEN 6
`define ACC_BIT_CONT 5
`define ACC_BIT_BREAK_CLEAR_ENABLE 0
`define ACC_BIT_BRK 1
`define ACC_BIT_STOP 2
`define ACC_BIT_ACLK 3
`define ACC_BIT_MODE0 2
`define ACC_BIT_LSMP 4
`define ACC_CH_OFF 5'h1F
`define ACC_SHORT_CYC 5'h04
`define ACC_LONG_CYC 5'h18
`define ACC_SAR_CYC 5'h0A
`endif

// file: verilog/acc_pkg.sv
// types for the conversion control block
// assumes acc_defines.svh for numeric constants
`default_nettype none
package acc_pkg;
   typedef enum logic [2:0] {
      ACC_IDLE = 3'b001,
      ACC_SAMPLE = 3'b010,
      ACC_CONVERT = 3'b100
   } acc_state_e;
endpackage : acc_pkg
`default_nettype wire

// file: sim/test_acc_conversion_control.sv
// self-checking bench for the conversion control block, drives the AXI4-Lite port itself
// assumes the design files under verilog/ and acc_defines.svh on the include path
`default_nettype none
`include "acc_defines.svh"
module test_acc_conversion_control;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // signals
   logic i_clk_sys = 1'b0;
   logic i_reset = 1'b1;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq, pwr, smp;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [31:0] rdata_q = 32'h0000_0000;
   logic [9:0] sar = 10'h000;
   logic [9:0] a_val;
   logic [4:0] chan;
   logic aw_hs = 1'b0, w_hs = 1'b0, b_hs = 1'b0, ar_hs = 1'b0, r_hs = 1'b0;
   logic [15:0] seed = 16'h0007;
   int failures = 0;
   int n_tests = 0;
   logic [31:0] q_exp[$];
   logic [31:0] q_msk[$];
   logic [1:0] q_rsp[$];
   logic [1:0] q_brsp[$];
   logic [31:0] m_exp, m_msk;
   logic [4:0] codes [10] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h1A, 5'h1D,
                              5'h1E, 5'h1B};
   always #12.5 i_clk_sys = ~i_clk_sys;
   acc_conversion_control DUT (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .i_sar_result(sar), .o_channel_select(chan), .o_converter_power(pwr),
      .o_sample_active(smp), .o_conversion_irq(irq));
   // ==========
   // handshake capture and read monitor
   always @(posedge i_clk_sys) begin
      aw_hs <= awvalid && awready;
      w_hs <= wvalid && wready;
      b_hs <= bvalid && bready;
      ar_hs <= arvalid && arready;
      r_hs <= rvalid && rready;
      rdata_q <= rdata;
   end
   always @(posedge i_clk_sys) begin
      if (bvalid === 1'b1 && bready === 1'b1 && q_brsp.size() > 0) begin
         chk("bresp", 32'(q_brsp.pop_front()), 32'(bresp));
      end
      if (rvalid === 1'b1 && rready === 1'b1 && q_exp.size() > 0) begin
         m_exp = q_exp.pop_front();
         m_msk = q_msk.pop_front();
         if (m_msk != 32'h0000_0000) chk("rdata", m_exp & m_msk, rdata & m_msk);
         chk("rresp", 32'(q_rsp.pop_front()), 32'(rresp));
      end
   end
   // ==========
   // tasks
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic tmo();
      failures++;
      $display("Error handshake expected answer seen none");
      test_done();
   endtask : tmo
   task automatic idle(input int c);
      repeat (c) @(posedge i_clk_sys);
      #1;
   endtask : idle
   task automatic wr(input logic [7:0] a, input logic [31:0] dt, input logic [1:0] p);
      int n;
      q_brsp.push_back(p);
      awaddr <= a;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         idle(1);
         if (aw_hs) awvalid <= 1'b0;
         if (w_hs) wvalid <= 1'b0;
         if (b_hs) break;
      end
      bready <= 1'b0;
      idle(1);
      if (n >= 50) tmo();
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                     input logic [1:0] p, output logic [31:0] dt);
      int n;
      q_exp.push_back(e);
      q_msk.push_back(m);
      q_rsp.push_back(p);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++) begin
         idle(1);
         if (ar_hs) arvalid <= 1'b0;
         if (r_hs) break;
      end
      rready <= 1'b0;
      dt = rdata_q;
      idle(1);
      if (n >= 50) tmo();
   endtask : rd
   task automatic rx(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      logic [31:0] dt;
      rd(a, e, m, 2'b00, dt);
   endtask : rx
   task automatic wait_done();
      int n;
      logic [31:0] dt;
      for (n = 0; n < 100; n++) begin
         rd(`ACC_OFF_SCR, 32'h0000_0000, 32'h0000_0000, 2'b00, dt);
         if (dt[`ACC_BIT_DONE] === 1'b1) break;
      end
      if (n >= 100) tmo();
   endtask : wait_done
   // ==========
   // main sequence
   initial begin
      logic [31:0] dt;
      repeat (12) @(posedge i_clk_sys);
      i_reset <= 1'b0;
      idle(1);
      chk("channel", 32'h0000_001F, 32'(chan));
      chk("power", 32'h0000_0000, 32'(pwr));
      rx(`ACC_OFF_SCR, 32'h0000_001F, 32'h0000_00FF);
      rd(8'h14, 32'h0000_0000, 32'hFFFF_FFFF, 2'b10, dt);
      wr(8'h14, 32'h0000_0000, 2'b10);
      wr(`ACC_OFF_SCR, 32'h0000_009F, 2'b00);
      idle(30);
      rx(`ACC_OFF_SCR, 32'h0000_001F, 32'h0000_00FF);
      chk("power", 32'h0000_0000, 32'(pwr));
      for (int i = 0; i < 10; i++) begin
         seed = lfsr(seed);
         sar <= seed[9:0];
         wr(`ACC_OFF_SCR, 32'h0000_0040 | 32'(codes[i]), 2'b00);
         idle(2);
         chk("power", 32'h0000_0001, 32'(pwr));
         chk("sample", 32'h0000_0001, 32'(smp));
         chk("channel", 32'(codes[i]), 32'(chan));
         wait_done();
         chk("irq", 32'h0000_0001, 32'(irq));
         chk("power", 32'h0000_0000, 32'(pwr));
         chk("sample", 32'h0000_0000, 32'(smp));
         rx(`ACC_OFF_RESL, 32'(seed[9:2]), 32'h0000_00FF);
         chk("irq", 32'h0000_0000, 32'(irq));
         idle(40);
         rx(`ACC_OFF_SCR, 32'h0000_0040 | 32'(codes[i]), 32'h0000_00FF);
      end
      wr(`ACC_OFF_SCR, 32'h0000_0022, 2'b00);
      seed = lfsr(seed);
      sar <= seed[9:0];
      wait_done();
      rx(`ACC_OFF_RESL, 32'h0000_0000, 32'h0000_0000);
      wait_done();
      rx(`ACC_OFF_RESL, 32'(seed[9:2]), 32'h0000_00FF);
      chk("power", 32'h0000_0001, 32'(pwr));
      wr(`ACC_OFF_CLK, 32'h0000_0000, 2'b00);
      idle(40);
      chk("power", 32'h0000_0000, 32'(pwr));
      wr(`ACC_OFF_SCR, 32'h0000_0022, 2'b00);
      idle(20);
      wr(`ACC_OFF_SCR, 32'h0000_003F, 2'b00);
      idle(40);
      rx(`ACC_OFF_SCR, 32'h0000_003F, 32'h0000_00FF);
      chk("power", 32'h0000_0000, 32'(pwr));
      wr(`ACC_OFF_SCR, 32'h0000_0022, 2'b00);
      idle(4);
      wr(`ACC_OFF_SYS, 32'h0000_0004, 2'b00);
      idle(2);
      chk("power", 32'h0000_0000, 32'(pwr));
      wr(`ACC_OFF_SYS, 32'h0000_0000, 2'b00);
      idle(40);
      chk("power", 32'h0000_0000, 32'(pwr));
      wr(`ACC_OFF_SCR, 32'h0000_0022, 2'b00);
      idle(2);
      chk("power", 32'h0000_0001, 32'(pwr));
      wr(`ACC_OFF_SCR, 32'h0000_0001, 2'b00);
      wait_done();
      wr(`ACC_OFF_SYS, 32'h0000_0002, 2'b00);
      rx(`ACC_OFF_RESL, 32'h0000_0000, 32'h0000_0000);
      rx(`ACC_OFF_SCR, 32'h0000_0081, 32'h0000_00FF);
      wr(`ACC_OFF_SYS, 32'h0000_0003, 2'b00);
      rx(`ACC_OFF_RESL, 32'h0000_0000, 32'h0000_0000);
      rx(`ACC_OFF_SCR, 32'h0000_0001, 32'h0000_00FF);
      wr(`ACC_OFF_SYS, 32'h0000_0000, 2'b00);
      rx(`ACC_OFF_SCR, 32'h0000_0001, 32'h0000_00FF);
      wr(`ACC_OFF_CLK, 32'h0000_0004, 2'b00);
      seed = lfsr(seed);
      a_val = seed[9:0];
      sar <= a_val;
      wr(`ACC_OFF_SCR, 32'h0000_0001, 2'b00);
      wait_done();
      rx(`ACC_OFF_RESH, 32'(a_val[9:8]), 32'h0000_00FF);
      wr(`ACC_OFF_SYS, 32'h0000_0002, 2'b00);
      rx(`ACC_OFF_RESL, 32'h0000_0000, 32'h0000_0000);
      wr(`ACC_OFF_SYS, 32'h0000_0000, 2'b00);
      seed = lfsr(seed);
      sar <= seed[9:0];
      wr(`ACC_OFF_SCR, 32'h0000_0001, 2'b00);
      wait_done();
      rx(`ACC_OFF_RESL, 32'(a_val[7:0]), 32'h0000_00FF);
      wr(`ACC_OFF_SCR, 32'h0000_0001, 2'b00);
      wait_done();
      rx(`ACC_OFF_RESL, 32'(seed[7:0]), 32'h0000_00FF);
      seed = lfsr(seed);
      sar <= seed[9:0];
      wr(`ACC_OFF_CLK, 32'h0000_0010, 2'b00);
      wr(`ACC_OFF_SCR, 32'h0000_0001, 2'b00);
      idle(8);
      chk("sample", 32'h0000_0001, 32'(smp));
      wait_done();
      rx(`ACC_OFF_RESL, 32'(seed[9:2]), 32'h0000_00FF);
      test_done();
   end
endmodule : test_acc_conversion_control
`default_nettype wire
